// >>> tx_power_ramp_sequencer.sv
// amplifier level ramp sequencer with its two configuration registers
`timescale 1ns/100ps
module tx_power_ramp_sequencer #(
  parameter int unsigned WAKE_CYCLES = pa_ramp_pkg::WAKE_CYC,
  parameter int unsigned LOCK_CYCLES = pa_ramp_pkg::LOCK_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic mode_pin,
  input wire logic power_state_select,
  input wire logic tx_done,
  output logic [pa_ramp_pkg::LEVEL_W:0] pa_stage,
  output logic pa_enable,
  output logic synth_on,
  output logic tx_active,
  output logic ready
);
  localparam int TW = 24;
  logic rst_a_ff, rst_int_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_a_ff <= 1'b0;
      rst_int_n <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_int_n <= rst_a_ff;
    end
  end

  // three-stage pin sampling; change seen when stages two and three agree
  logic [2:0] mode_s_ff, power_state_select_s_ff;
  logic mode_q_ff, power_state_select_q_ff;
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      mode_s_ff <= 3'b000;
      power_state_select_s_ff <= 3'b000;
      mode_q_ff <= 1'b0;
      power_state_select_q_ff <= 1'b0;
    end else begin
      mode_s_ff <= {mode_s_ff[1:0], mode_pin};
      power_state_select_s_ff <= {power_state_select_s_ff[1:0], power_state_select};
      if (mode_s_ff[1] == mode_s_ff[2]) begin
        mode_q_ff <= mode_s_ff[2];
      end
      if (power_state_select_s_ff[1] == power_state_select_s_ff[2]) begin
        power_state_select_q_ff <= power_state_select_s_ff[2];
      end
    end
  end
  logic mode_d_ff;
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      mode_d_ff <= 1'b0;
    end else begin
      mode_d_ff <= mode_q_ff;
    end
  end
  wire logic mode_fall = mode_d_ff && !mode_q_ff;
  // sleep is power state low with mode high; leaving it re-runs the wake wait
  wire logic in_sleep = !power_state_select_q_ff && mode_q_ff;

  logic [7:0] tx_power_config_ff, pa_ramp_config_ff;
  wire logic sel_pwr = (cfg_addr == pa_ramp_pkg::TX_POWER_CONFIG_OFS);
  wire logic sel_ramp = (cfg_addr == pa_ramp_pkg::PA_RAMP_CONFIG_OFS);
  wire logic [7:0] rd_mux = sel_pwr ? tx_power_config_ff : (sel_ramp ? pa_ramp_config_ff : 8'h00);
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      tx_power_config_ff <= pa_ramp_pkg::TX_POWER_CONFIG_RST;
      pa_ramp_config_ff <= pa_ramp_pkg::PA_RAMP_CONFIG_RST;
      cfg_rdata <= 8'h00;
    end else begin
      if (cfg_wr && sel_pwr) begin
        tx_power_config_ff <= cfg_wdata;
      end
      if (cfg_wr && sel_ramp) begin
        pa_ramp_config_ff <= cfg_wdata;
      end
      cfg_rdata <= rd_mux;
    end
  end

  // target stage 1..4; stage 0 is amplifier off
  wire logic [pa_ramp_pkg::LEVEL_W-1:0] level_sel =
    tx_power_config_ff[pa_ramp_pkg::LEVEL_LSB +: pa_ramp_pkg::LEVEL_W];
  wire logic [pa_ramp_pkg::LEVEL_W:0] target_stage = {1'b0, level_sel} + 3'd1;
  wire logic [pa_ramp_pkg::RAMP_W-1:0] ramp_up_step_setting =
    pa_ramp_config_ff[pa_ramp_pkg::RU_LSB +: pa_ramp_pkg::RAMP_W];
  wire logic [pa_ramp_pkg::RAMP_W-1:0] ramp_down_step_setting =
    pa_ramp_config_ff[pa_ramp_pkg::RD_LSB +: pa_ramp_pkg::RAMP_W];
  // field value n gives (n+1) base steps so zero never stalls the ramp
  wire logic [TW-1:0] up_cyc =
    TW'((32'(ramp_up_step_setting) + 32'd1) * pa_ramp_pkg::STEP_UP_CYC);
  wire logic [TW-1:0] dn_cyc =
    TW'((32'(ramp_down_step_setting) + 32'd1) * pa_ramp_pkg::STEP_DN_CYC);

  pa_ramp_pkg::ramp_state_t state_ff, nxt_state;
  logic [pa_ramp_pkg::LEVEL_W:0] stage_ff, nxt_stage;
  logic load;
  logic [TW-1:0] load_val;
  logic tmr_done;
  // wake wait restarts on leaving sleep; timer seeded right after reset
  logic boot_ff, sleep_d_ff;
  wire logic wake_start = boot_ff || (sleep_d_ff && !in_sleep);
  // wake wait shares the step timer; no ramp load can fall in the same cycle
  wire logic tmr_load = load || wake_start;
  wire logic [TW-1:0] tmr_val = wake_start ? TW'(WAKE_CYCLES) : load_val;

  step_timer #(.W(TW)) u_timer (
    .clk(clk),
    .rst_int_n(rst_int_n),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_stage = stage_ff;
    load = 1'b0;
    load_val = '0;
    case (state_ff)
      pa_ramp_pkg::ST_WAKE: begin
        if (tmr_done && !wake_start) begin
          nxt_state = pa_ramp_pkg::ST_IDLE;
        end
      end
      pa_ramp_pkg::ST_IDLE: begin
        nxt_stage = '0;
        if (mode_fall && power_state_select_q_ff) begin
          nxt_state = pa_ramp_pkg::ST_LOCK;
          load = 1'b1;
          load_val = TW'(LOCK_CYCLES);
        end
      end
      pa_ramp_pkg::ST_LOCK: begin
        if (tmr_done) begin
          nxt_state = pa_ramp_pkg::ST_UP;
          nxt_stage = 3'd1;
          load = 1'b1;
          load_val = up_cyc;
        end
      end
      pa_ramp_pkg::ST_UP: begin
        if (tmr_done) begin
          if (stage_ff >= target_stage) begin
            nxt_state = pa_ramp_pkg::ST_ON;
          end else begin
            nxt_stage = stage_ff + 3'd1;
            load = 1'b1;
            load_val = up_cyc;
          end
        end
      end
      pa_ramp_pkg::ST_ON: begin
        if (tx_done) begin
          nxt_state = pa_ramp_pkg::ST_DOWN;
          load = 1'b1;
          load_val = dn_cyc;
        end
      end
      pa_ramp_pkg::ST_DOWN: begin
        if (tmr_done) begin
          nxt_stage = stage_ff - 3'd1;
          if (stage_ff == 3'd1) begin
            nxt_state = pa_ramp_pkg::ST_IDLE;
          end else begin
            load = 1'b1;
            load_val = dn_cyc;
          end
        end
      end
      default: begin
        nxt_state = pa_ramp_pkg::ST_IDLE;
        nxt_stage = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      state_ff <= pa_ramp_pkg::ST_WAKE;
      stage_ff <= '0;
      boot_ff <= 1'b1;
      sleep_d_ff <= 1'b0;
      pa_stage <= '0;
      pa_enable <= 1'b0;
      synth_on <= 1'b0;
      tx_active <= 1'b0;
      ready <= 1'b0;
    end else begin
      boot_ff <= 1'b0;
      sleep_d_ff <= in_sleep;
      if (in_sleep) begin
        state_ff <= pa_ramp_pkg::ST_WAKE;
        stage_ff <= '0;
      end else begin
        state_ff <= nxt_state;
        stage_ff <= nxt_stage;
      end
      pa_stage <= in_sleep ? '0 : nxt_stage;
      pa_enable <= !in_sleep && (nxt_stage != '0);
      synth_on <= !in_sleep && (nxt_state inside {pa_ramp_pkg::ST_LOCK, pa_ramp_pkg::ST_UP,
        pa_ramp_pkg::ST_ON, pa_ramp_pkg::ST_DOWN});
      tx_active <= !in_sleep && (nxt_state == pa_ramp_pkg::ST_ON);
      ready <= !in_sleep && (nxt_state == pa_ramp_pkg::ST_IDLE);
    end
  end

endmodule // tx_power_ramp_sequencer

// >>> pa_ramp_pkg.sv
// constants for the transmit power ramp sequencer
package pa_ramp_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam logic [7:0] TX_POWER_CONFIG_OFS = 8'h01;
  localparam logic [7:0] PA_RAMP_CONFIG_OFS = 8'h07;
  localparam logic [7:0] TX_POWER_CONFIG_RST = 8'h03;
  localparam logic [7:0] PA_RAMP_CONFIG_RST = 8'h11;
  localparam int unsigned LEVEL_LSB = 0;
  localparam int unsigned LEVEL_W = 2;
  localparam int unsigned RU_LSB = 4;
  localparam int unsigned RD_LSB = 0;
  localparam int unsigned RAMP_W = 4;
  localparam int unsigned NUM_LEVELS = 4;
  localparam int unsigned WAKE_MS = 120;
  localparam int unsigned SWITCH_US = 200;
  localparam int unsigned LOCK_US = 170;
  localparam int unsigned STEP_UP_US = 10;
  localparam int unsigned STEP_DN_US = 5;
  localparam int unsigned WAKE_CYC = WAKE_MS * (CLK_HZ / 1000);
  localparam int unsigned SWITCH_CYC = SWITCH_US * (CLK_HZ / 1_000_000);
  localparam int unsigned LOCK_CYC = LOCK_US * (CLK_HZ / 1_000_000);
  localparam int unsigned STEP_UP_CYC = STEP_UP_US * (CLK_HZ / 1_000_000);
  localparam int unsigned STEP_DN_CYC = STEP_DN_US * (CLK_HZ / 1_000_000);
  typedef enum logic [2:0] {ST_WAKE, ST_IDLE, ST_LOCK, ST_UP, ST_ON, ST_DOWN} ramp_state_t;
endpackage

// >>> step_timer.sv
// down counter giving one-cycle done pulse
`timescale 1ns/100ps
module step_timer #(
  parameter int W = 24
) (
  input wire logic clk,
  input wire logic rst_int_n,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic done
);
  logic [W-1:0] cnt_ff;
  logic run_ff;
  wire logic at_one = (cnt_ff == W'(1));
  // combinational so that a load of n spans exactly n cycles to the next action
  assign done = run_ff && at_one;
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
    end else begin
      if (load) begin
        cnt_ff <= load_val;
        run_ff <= 1'b1;
      end else if (run_ff) begin
        cnt_ff <= cnt_ff - W'(1);
        if (at_one) begin
          run_ff <= 1'b0;
        end
      end
    end
  end
endmodule // step_timer

// >>> host_model.sv
// host side: wake wait, then bursts launched by a mode falling edge
`timescale 1ns/100ps
module host_model #(
  parameter int unsigned WAKE_CYCLES = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fire,
  input wire logic sleep_req,
  output logic mode_pin,
  output logic power_state_select
);
  int unsigned wake_ff;
  logic [7:0] low_ff;
  assign mode_pin = (low_ff == 8'h00);
  assign power_state_select = !sleep_req;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_ff <= 0;
      low_ff <= 8'h00;
    end else begin
      if (sleep_req) wake_ff <= 0;
      else if (wake_ff < WAKE_CYCLES) wake_ff <= wake_ff + 1;
      // requests before the wake wait are dropped
      if (fire && wake_ff == WAKE_CYCLES) low_ff <= 8'h14;
      else if (low_ff != 8'h00) low_ff <= low_ff - 8'h01;
    end
  end
endmodule // host_model

// >>> tx_power_ramp_props.sv
// port assertions for the ramp sequencer
`timescale 1ns/100ps
module tx_power_ramp_props #(
  parameter int unsigned WAKE_CYCLES = 10,
  parameter int unsigned LOCK_CYCLES = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_done,
  input wire logic [pa_ramp_pkg::LEVEL_W:0] pa_stage,
  input wire logic pa_enable,
  input wire logic synth_on,
  input wire logic tx_active,
  input wire logic ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_en; pa_enable == (pa_stage != 3'h0); endproperty
  a_en: assert property (p_en) else $error("enable and stage disagree");
  property p_max; pa_stage <= 3'h4; endproperty
  a_max: assert property (p_max) else $error("stage above top");
  property p_one; $changed(pa_stage) |-> (pa_stage == $past(pa_stage) + 3'h1 || pa_stage == $past(pa_stage) - 3'h1);
  endproperty
  a_one: assert property (p_one) else $error("stage jumped");
  property p_first; $rose(pa_enable) |-> pa_stage == 3'h1 && $past(synth_on, LOCK_CYCLES); endproperty
  a_first: assert property (p_first) else $error("ramp began early or high");
  // shortest programmed hold is 50 cycles, so 8 is safe for ramp steps but not for a sleep drop or a LOCK_CYCLES under 8
  property p_hold; $changed(pa_stage) |=> $stable(pa_stage) [*8]; endproperty
  a_hold: assert property (p_hold) else $error("stage not held");
  property p_full; tx_active |-> pa_enable && synth_on; endproperty
  a_full: assert property (p_full) else $error("active without amplifier");
  property p_idle; ready |-> pa_stage == 3'h0 && !tx_active; endproperty
  a_idle: assert property (p_idle) else $error("ready while ramped");
  property p_down; tx_done && tx_active |-> ##[1:1000] (pa_stage < $past(pa_stage)); endproperty
  a_down: assert property (p_down) else $error("no ramp down");
  c_full: cover property ($rose(tx_active));
  c_off: cover property ($fell(pa_enable));
  c_ready: cover property ($rose(ready));
endmodule // tx_power_ramp_props
bind tx_power_ramp_sequencer tx_power_ramp_props #(.WAKE_CYCLES(WAKE_CYCLES), .LOCK_CYCLES(LOCK_CYCLES)) u_props (
  .clk(clk), .rst_n(rst_n), .tx_done(tx_done), .pa_stage(pa_stage), .pa_enable(pa_enable),
  .synth_on(synth_on), .tx_active(tx_active), .ready(ready));

// >>> tx_power_ramp_sequencer_tb_top.sv
// testbench: register access and full bursts at every level
`timescale 1ns/100ps
module tx_power_ramp_sequencer_tb_top;
  logic clk = 0, rst_n = 0, cfg_wr = 0, tx_done = 0, fire = 0, sleep_req = 0;
  logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata;
  logic mode_pin, power_state_select, pa_enable, synth_on, tx_active, ready;
  logic [pa_ramp_pkg::LEVEL_W:0] pa_stage;
  int errors = 0, n_tests = 0;
  initial begin
    forever #50 clk = ~clk;
  end
  tx_power_ramp_sequencer #(.WAKE_CYCLES(10), .LOCK_CYCLES(5)) dut (.clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .mode_pin(mode_pin),
    .power_state_select(power_state_select), .tx_done(tx_done), .pa_stage(pa_stage), .pa_enable(pa_enable),
    .synth_on(synth_on), .tx_active(tx_active), .ready(ready));
  host_model #(.WAKE_CYCLES(10)) host (.clk(clk), .rst_n(rst_n), .fire(fire), .sleep_req(sleep_req), .mode_pin(mode_pin),
    .power_state_select(power_state_select));
  task automatic end_of_test;
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_v(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp, input string m);
    n_tests++;
    if (got != exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %0d want %0d", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1;
    @(negedge clk);
    cfg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    cfg_addr = a;
    @(negedge clk);
    d = cfg_rdata;
  endtask
  task automatic idle;
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    chk_v({7'h00, ready}, 8'h01, "ready");
    if (n >= 5000) end_of_test();
  endtask
  // hold is counted from the previous change, so calls must follow each other directly
  task automatic step(input logic [2:0] e, input int hold);
    int n;
    logic [2:0] p;
    n = 0;
    p = pa_stage;
    while (pa_stage === p && n < 5000) begin
      @(negedge clk);
      n++;
    end
    chk_v({5'h00, pa_stage}, {5'h00, e}, "stage");
    if (hold > 0) chk_n(n, hold, "hold");
    if (n >= 5000) end_of_test();
  endtask
  task automatic burst(input int lvl, input int ru, input int rdf);
    int k, n;
    wr(8'h01, 8'(lvl));
    wr(8'h07, 8'(ru * 16 + rdf));
    idle();
    @(negedge clk);
    fire = 1;
    @(negedge clk);
    fire = 0;
    step(3'h1, 0);
    for (k = 2; k <= lvl + 1; k++) step(3'(k), (ru + 1) * 100);
    n = 0;
    while (tx_active !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    chk_v({7'h00, tx_active}, 8'h01, "full");
    chk_n(n, (ru + 1) * 100, "top hold");
    chk_v({6'h00, synth_on, pa_enable}, 8'h03, "amplifier on");
    if (n >= 5000) end_of_test();
    tx_done = 1;
    @(negedge clk);
    tx_done = 0;
    for (k = lvl; k >= 0; k--) step(3'(k), (rdf + 1) * 50);
    idle();
    $display("burst level %0d finished", lvl);
  endtask
  initial begin
    logic [7:0] d;
    repeat (20) @(negedge clk);
    rst_n = 1;
    // internal reset copy trails the pin by two edges
    repeat (2) @(negedge clk);
    rd(8'h01, d);
    chk_v(d, pa_ramp_pkg::TX_POWER_CONFIG_RST, "power reset");
    rd(8'h07, d);
    chk_v(d, pa_ramp_pkg::PA_RAMP_CONFIG_RST, "ramp reset");
    wr(8'h05, 8'hff);
    rd(8'h05, d);
    chk_v(d, 8'h00, "unmapped");
    wr(8'h07, 8'ha6);
    rd(8'h07, d);
    chk_v(d, 8'ha6, "ramp readback");
    $display("register test finished");
    for (int i = 0; i < 4; i++) burst(i, i, 3 - i);
    sleep_req = 1;
    repeat (10) @(negedge clk);
    chk_v({7'h00, ready}, 8'h00, "asleep");
    sleep_req = 0;
    repeat (10) @(negedge clk);
    chk_v({7'h00, ready}, 8'h00, "waking");
    $display("sleep test finished");
    burst(1, 0, 0);
    end_of_test();
  end
endmodule // tx_power_ramp_sequencer_tb_top
